/* design/rfw_engine.sv */
// forwarding engine of one output: round-robin or synchronized line scheduling
`timescale 1ns/1ns
module rfw_engine #(
  parameter int W = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic rr_en,
  input wire logic [1:0] sync_mode,
  input wire logic as_avail,
  input wire logic [3:0] elig,
  input wire logic [3:0] in_valid,
  input wire logic [3:0] in_last,
  input wire logic [3:0] in_short,
  input wire logic [4*W-1:0] in_data,
  output logic [3:0] in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  output logic out_last,
  output logic [1:0] out_src,
  input wire logic out_ready,
  output logic synced
);
  generate
    if (W < 1) begin : g_bad_w
      $error("W must be at least one");
    end
  endgenerate

  typedef struct packed {
    logic busy;
    logic [1:0] cur;
    logic [1:0] ptr;
    logic [3:0] served;
    logic ov;
    logic [W-1:0] od;
    logic ol;
    logic [1:0] os;
  } rfw_eng_t;

  rfw_eng_t st_r, st_nxt;
  logic sync_on, round_go, can_load, xfer, found;
  logic [3:0] avail, allow;
  logic [1:0] pick;

  // first allowed port at or after the pointer
  function automatic logic [2:0] pick_rr(input logic [3:0] req, input logic [1:0] ptr);
    logic [2:0] res;
    logic [1:0] idx;
    res = 3'h0;
    for (int i = 3; i >= 0; i--) begin
      idx = 2'(ptr + 2'(i));
      if (req[idx]) begin
        res = {1'b1, idx};
      end
    end
    return res;
  endfunction

  always_comb begin
    st_nxt = st_r;
    sync_on = sync_mode != rfw_pkg::SYNC_OFF;
    avail = in_valid & elig;
    round_go = sync_on && elig != 4'h0 && ((avail | st_r.served) & elig) == elig;
    if (rr_en) begin
      allow = avail;
    end else if (!sync_on) begin
      allow = 4'h0;
    end else if (round_go) begin
      allow = avail & ~st_r.served;
    end else if (as_avail && sync_mode != rfw_pkg::SYNC_CONCAT) begin
      allow = avail & ~st_r.served & ~in_short;
    end else begin
      allow = 4'h0;
    end
    {found, pick} = pick_rr(allow, st_r.ptr);
    can_load = !st_r.ov || out_ready;
    // no beat is accepted while the state is frozen
    in_ready = ce && st_r.busy && can_load ? 4'h1 << st_r.cur : 4'h0;
    xfer = st_r.busy && can_load && in_valid[st_r.cur];
    if (can_load) begin
      st_nxt.ov = xfer;
    end
    if (xfer) begin
      st_nxt.od = in_data[st_r.cur*W +: W];
      st_nxt.ol = in_last[st_r.cur];
      st_nxt.os = st_r.cur;
      if (in_last[st_r.cur]) begin
        st_nxt.busy = 1'b0;
        st_nxt.ptr = 2'(st_r.cur + 2'd1);
        if (sync_on) begin
          st_nxt.served = st_r.served | (4'h1 << st_r.cur);
        end
      end
    end
    if (!st_r.busy && found) begin
      st_nxt.busy = 1'b1;
      st_nxt.cur = pick;
    end
    st_nxt.served = st_nxt.served & elig;
    if (!sync_on || st_nxt.served == elig) begin
      st_nxt.served = 4'h0;
    end
    synced = sync_on && elig != 4'h0 && (round_go || st_r.busy);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign out_valid = st_r.ov;
  assign out_data = st_r.od;
  assign out_last = st_r.ol;
  assign out_src = st_r.os;

  a_sync_gate: assert property (@(posedge clk) disable iff (rst)
    ce && !st_r.busy && st_nxt.busy && !rr_en && !as_avail |-> round_go)
    else $error("synchronized line started before all ports were ready");
  a_out_hold: assert property (@(posedge clk) disable iff (rst)
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("output beat changed while stalled");
  a_idle_mode: assert property (@(posedge clk) disable iff (rst)
    !rr_en && !sync_on |-> !found)
    else $error("port picked with forwarding off");
endmodule

/* design/rfw_pkg.sv */
// register map, field positions and mode codes of the video forwarding router
package rfw_pkg;
  localparam logic [7:0] IDX_PORT_CTL = 8'h20;
  localparam logic [7:0] IDX_MODE_CTL = 8'h21;
  localparam logic [7:0] IDX_STATUS = 8'h22;
  localparam logic [11:0] ADDR_PORT_CTL = {2'b00, IDX_PORT_CTL, 2'b00};
  localparam logic [11:0] ADDR_MODE_CTL = {2'b00, IDX_MODE_CTL, 2'b00};
  localparam logic [11:0] ADDR_STATUS = {2'b00, IDX_STATUS, 2'b00};
  localparam int BLOCK_LSB = 4;
  localparam int ROUTE_LSB = 0;
  localparam int REPLICATE_BIT = 7;
  localparam int SEND_READY_BIT = 6;
  localparam int OUT1_SYNC_LSB = 4;
  localparam int OUT0_SYNC_LSB = 2;
  localparam int OUT1_RR_BIT = 1;
  localparam int OUT0_RR_BIT = 0;
  localparam logic [7:0] PORT_CTL_RST = 8'hf0;
  localparam logic [7:0] MODE_CTL_RST = 8'h03;
  localparam logic [1:0] SYNC_OFF = 2'h0;
  localparam logic [1:0] SYNC_BASIC = 2'h1;
  localparam logic [1:0] SYNC_INTERLEAVE = 2'h2;
  localparam logic [1:0] SYNC_CONCAT = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int NUM_RX = 4;
endpackage

/* design/rfw_router.sv */
// video forwarding router: register slave, port routing and two output engines
// Summary of operation
// - bits 7..4 of the port control register block forwarding of ports 3..0, reset to one.
// - bits 3..0 of the port control register route ports 3..0 to output 0 or 1, reset zero.
// - with the replicate bit set, output 1 carries exactly the data of output 0.
// - in synchronized forwarding a line waits until every enabled routed port has data; send-when-ready exempts non-short lines outside concat mode.
// - the one send-when-ready bit governs both output engines.
// - bits 5:4 pick the synchronized mode of output 1, reset to disabled.
// - bits 3:2 pick the synchronized mode of output 0, reset to disabled.
// - best-effort mode does not synchronize and serves ready sources round-robin.
// - bits 1 and 0 enable round-robin on outputs 1 and 0, both reset to one.
// - the synchronized status of an output reads zero while its synchronized mode is off.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module rfw_router #(
  parameter int VID_W = 32
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic [11:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [11:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire logic [3:0] RX_VALID,
  input wire logic [4*VID_W-1:0] RX_DATA,
  input wire logic [3:0] RX_LAST,
  input wire logic [3:0] RX_SHORT,
  output logic [3:0] RX_READY,
  output logic OUT0_VALID,
  output logic [VID_W-1:0] OUT0_DATA,
  output logic OUT0_LAST,
  output logic [1:0] OUT0_SRC,
  input wire logic OUT0_READY,
  output logic OUT1_VALID,
  output logic [VID_W-1:0] OUT1_DATA,
  output logic OUT1_LAST,
  output logic [1:0] OUT1_SRC,
  input wire logic OUT1_READY
);
  generate
    if (VID_W < 1) begin : g_bad_width
      $error("VID_W must be at least one");
    end
  endgenerate

  typedef struct packed {
    logic [7:0] port_ctl;
    logic [7:0] mode_ctl;
    logic aw_got;
    logic w_got;
    logic [11:0] aw_addr;
    logic [7:0] w_byte;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rfw_regs_t;

  rfw_regs_t st_r, st_nxt;
  logic [3:0] rx_block, rx_route, elig0, elig1, ready0, ready1;
  logic replicate, send_ready, rr0, rr1, synced0, synced1;
  logic [1:0] sync0, sync1;
  logic e0_valid, e0_last, e1_valid, e1_last, e0_ready;
  logic [VID_W-1:0] e0_data, e1_data;
  logic [1:0] e0_src, e1_src;
  logic aw_hs, w_hs, ar_hs;

  // mapped word address check
  function automatic logic is_mapped(input logic [11:0] addr);
    return addr == rfw_pkg::ADDR_PORT_CTL || addr == rfw_pkg::ADDR_MODE_CTL ||
           addr == rfw_pkg::ADDR_STATUS;
  endfunction

  assign rx_block = st_r.port_ctl[rfw_pkg::BLOCK_LSB +: 4];
  assign rx_route = st_r.port_ctl[rfw_pkg::ROUTE_LSB +: 4];
  assign replicate = st_r.mode_ctl[rfw_pkg::REPLICATE_BIT];
  assign send_ready = st_r.mode_ctl[rfw_pkg::SEND_READY_BIT];
  assign sync1 = st_r.mode_ctl[rfw_pkg::OUT1_SYNC_LSB +: 2];
  assign sync0 = st_r.mode_ctl[rfw_pkg::OUT0_SYNC_LSB +: 2];
  assign rr1 = st_r.mode_ctl[rfw_pkg::OUT1_RR_BIT];
  assign rr0 = st_r.mode_ctl[rfw_pkg::OUT0_RR_BIT];

  // engine 1 is starved while it only mirrors engine 0
  assign elig0 = ~rx_block & ~rx_route;
  assign elig1 = replicate ? 4'h0 : ~rx_block & rx_route;

  // requests are refused while the state is frozen, so none is lost
  assign AWREADY = CE && !st_r.aw_got && !st_r.bvalid;
  assign WREADY = CE && !st_r.w_got && !st_r.bvalid;
  assign ARREADY = CE && !st_r.rvalid;
  assign aw_hs = AWVALID && AWREADY;
  assign w_hs = WVALID && WREADY;
  assign ar_hs = ARVALID && ARREADY;

  always_comb begin
    st_nxt = st_r;
    if (aw_hs) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.aw_addr = {AWADDR[11:2], 2'b00};
    end
    if (w_hs) begin
      st_nxt.w_got = 1'b1;
      st_nxt.w_byte = WDATA[7:0];
      st_nxt.w_lane0 = WSTRB[0];
    end
    if (st_nxt.aw_got && st_nxt.w_got) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = is_mapped(st_nxt.aw_addr) ? rfw_pkg::RESP_OKAY : rfw_pkg::RESP_SLVERR;
      if (st_nxt.w_lane0 && st_nxt.aw_addr == rfw_pkg::ADDR_PORT_CTL) begin
        st_nxt.port_ctl = st_nxt.w_byte;
      end
      if (st_nxt.w_lane0 && st_nxt.aw_addr == rfw_pkg::ADDR_MODE_CTL) begin
        st_nxt.mode_ctl = st_nxt.w_byte;
      end
    end
    if (st_r.bvalid && BREADY) begin
      st_nxt.bvalid = 1'b0;
    end
    if (st_r.rvalid && RREADY) begin
      st_nxt.rvalid = 1'b0;
    end
    if (ar_hs) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = rfw_pkg::RESP_OKAY;
      case ({ARADDR[11:2], 2'b00})
        rfw_pkg::ADDR_PORT_CTL: begin
          st_nxt.rdata = {24'h00_0000, st_r.port_ctl};
        end
        rfw_pkg::ADDR_MODE_CTL: begin
          st_nxt.rdata = {24'h00_0000, st_r.mode_ctl};
        end
        rfw_pkg::ADDR_STATUS: begin
          st_nxt.rdata = {30'h0000_0000, synced1, synced0};
        end
        default: begin
          st_nxt.rdata = 32'h0000_0000;
          st_nxt.rresp = rfw_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      st_r <= '0;
      st_r.port_ctl <= rfw_pkg::PORT_CTL_RST;
      st_r.mode_ctl <= rfw_pkg::MODE_CTL_RST;
    end else if (CE) begin
      st_r <= st_nxt;
    end
  end

  assign BVALID = st_r.bvalid;
  assign BRESP = st_r.bresp;
  assign RVALID = st_r.rvalid;
  assign RDATA = st_r.rdata;
  assign RRESP = st_r.rresp;

  // in replicate mode output 0 advances only when both sinks take the beat
  assign e0_ready = replicate ? OUT0_READY && OUT1_READY : OUT0_READY;

  rfw_engine #(.W(VID_W)) u_eng0 (
    .clk(CLK),
    .rst(RST),
    .ce(CE),
    .rr_en(rr0),
    .sync_mode(sync0),
    .as_avail(send_ready),
    .elig(elig0),
    .in_valid(RX_VALID),
    .in_last(RX_LAST),
    .in_short(RX_SHORT),
    .in_data(RX_DATA),
    .in_ready(ready0),
    .out_valid(e0_valid),
    .out_data(e0_data),
    .out_last(e0_last),
    .out_src(e0_src),
    .out_ready(e0_ready),
    .synced(synced0)
  );

  rfw_engine #(.W(VID_W)) u_eng1 (
    .clk(CLK),
    .rst(RST),
    .ce(CE),
    .rr_en(rr1),
    .sync_mode(sync1),
    .as_avail(send_ready),
    .elig(elig1),
    .in_valid(RX_VALID),
    .in_last(RX_LAST),
    .in_short(RX_SHORT),
    .in_data(RX_DATA),
    .in_ready(ready1),
    .out_valid(e1_valid),
    .out_data(e1_data),
    .out_last(e1_last),
    .out_src(e1_src),
    .out_ready(OUT1_READY),
    .synced(synced1)
  );

  // a port is served only by the engine it is routed to
  assign RX_READY = (ready0 & elig0) | (ready1 & elig1);
  assign OUT0_VALID = e0_valid;
  assign OUT0_DATA = e0_data;
  assign OUT0_LAST = e0_last;
  assign OUT0_SRC = e0_src;
  assign OUT1_VALID = replicate ? e0_valid : e1_valid;
  assign OUT1_DATA = replicate ? e0_data : e1_data;
  assign OUT1_LAST = replicate ? e0_last : e1_last;
  assign OUT1_SRC = replicate ? e0_src : e1_src;

  a_ctl_reset: assert property (@(posedge CLK)
    $past(RST) |-> st_r.port_ctl == 8'hf0 && st_r.mode_ctl == 8'h03)
    else $error("control registers not at reset values");
  a_block_port: assert property (@(posedge CLK) disable iff (RST)
    rx_block[0] |-> !RX_READY[0])
    else $error("blocked port 0 was served");
  a_route_out1: assert property (@(posedge CLK) disable iff (RST)
    !rx_route[3] |-> !ready1[3])
    else $error("port 3 served by output 1 while routed to output 0");
  a_repl_mirror: assert property (@(posedge CLK) disable iff (RST)
    replicate |-> OUT1_VALID == OUT0_VALID && OUT1_DATA == OUT0_DATA)
    else $error("replicated output differs from output 0");
  a_status_zero: assert property (@(posedge CLK) disable iff (RST)
    sync0 == 2'h0 && sync1 == 2'h0 && ar_hs && CE && ARADDR[11:2] == 10'h022
    |=> RDATA[1:0] == 2'h0)
    else $error("synchronized status set with sync forwarding off");
  a_write_mode: assert property (@(posedge CLK) disable iff (RST)
    CE && aw_hs && w_hs && AWADDR == 12'h084 && WSTRB[0]
    |=> st_r.mode_ctl == $past(WDATA[7:0]) && BVALID)
    else $error("mode register write not applied");
  a_bad_read: assert property (@(posedge CLK) disable iff (RST)
    CE && ar_hs && !is_mapped({ARADDR[11:2], 2'b00}) |=> RVALID && RRESP == 2'h2)
    else $error("unmapped read not refused");
  a_resp_hold: assert property (@(posedge CLK) disable iff (RST)
    BVALID && !BREADY |=> BVALID)
    else $error("write response dropped before taken");
  a_read_port: assert property (@(posedge CLK) disable iff (RST)
    CE && ar_hs && ARADDR[11:2] == 10'h020
    |=> RDATA == {24'h00_0000, $past(st_r.port_ctl)})
    else $error("port control read back wrong");
  a_write_port: assert property (@(posedge CLK) disable iff (RST)
    CE && aw_hs && w_hs && AWADDR == 12'h080 && WSTRB[0]
    |=> st_r.port_ctl == $past(WDATA[7:0]))
    else $error("port control write not applied");
  a_sync_flag_off: assert property (@(posedge CLK) disable iff (RST)
    !(sync0 == 2'h0 && synced0) && !(sync1 == 2'h0 && synced1))
    else $error("synchronized flag set with sync forwarding off");

  c_repl: cover property (@(posedge CLK) disable iff (RST) replicate && OUT1_VALID && e0_ready);
  c_sync_status: cover property (@(posedge CLK) disable iff (RST) synced0 && OUT0_VALID);
  c_rr_two: cover property (@(posedge CLK) disable iff (RST) rr0 && RX_READY[0] ##[1:50] RX_READY[1]);
  c_send_ready: cover property (@(posedge CLK) disable iff (RST) send_ready && sync1 != 2'h0 && OUT1_VALID);
endmodule

/* dv/rfw_sink.sv */
// downstream video sink model: takes output beats with pseudo-random stalls
`timescale 1ns/1ns
module rfw_sink (
  input wire logic clk,
  input wire logic rst,
  output logic rdy0,
  output logic rdy1
);
  logic [7:0] st_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= 8'h5a;
      rdy0 <= 1'h0;
      rdy1 <= 1'h0;
    end else begin
      st_r <= {st_r[6:0], st_r[7] ^ st_r[5] ^ st_r[4] ^ st_r[3]};
      rdy0 <= st_r[0] | st_r[2];
      rdy1 <= st_r[1] | st_r[4];
    end
  end
endmodule

/* dv/tb_top.sv */
// self-checking bench of the video forwarding router
`timescale 1ns/1ns
module tb_top;
  logic clk, rst, ce, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, rep;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rs, r;
  logic [3:0] wstrb, rxv, rxl, rxs, rxr;
  logic [1:0] bresp, rresp, o0s, o1s;
  logic [127:0] rxd;
  logic o0v, o0l, o0r, o1v, o1l, o1r;
  logic [31:0] o0d, o1d;
  logic [32:0] exq [2][4][$];
  int n_tests, n_mismatch;

  rfw_router #(.VID_W(32)) uut (
    .CLK(clk), .RST(rst), .CE(ce), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
    .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .RX_VALID(rxv), .RX_DATA(rxd), .RX_LAST(rxl), .RX_SHORT(rxs), .RX_READY(rxr),
    .OUT0_VALID(o0v), .OUT0_DATA(o0d), .OUT0_LAST(o0l), .OUT0_SRC(o0s), .OUT0_READY(o0r),
    .OUT1_VALID(o1v), .OUT1_DATA(o1d), .OUT1_LAST(o1l), .OUT1_SRC(o1s), .OUT1_READY(o1r)
  );
  rfw_sink sink (.clk(clk), .rst(rst), .rdy0(o0r), .rdy1(o1r));

  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    rs = {rs[30:0], rs[31] ^ rs[21] ^ rs[1] ^ rs[0]};
    return rs;
  endfunction

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic to_fail();
    n_mismatch++;
    $display("wrong value at %0t: wait ran out", $time);
    print_verdict();
  endtask

  task automatic chk_reg(input logic [33:0] g, input logic [33:0] e);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: register got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_beat(input logic [35:0] g, input logic [35:0] e);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: beat got %h expected %h", $time, g, e);
    end
  endtask

  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid && bready) break;
    end
    bready <= 1'h0;
    if (i == 50) to_fail();
    chk_reg({bresp, 32'h0000_0000}, {er, 32'h0000_0000});
    @(posedge clk);
  endtask

  task automatic axr(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    int i;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid && rready) break;
    end
    rready <= 1'h0;
    if (i == 50) to_fail();
    chk_reg({rresp, rdata}, {er, ed});
    @(posedge clk);
  endtask

  // one packet of nb beats on port p, expected on output k
  task automatic send_pkt(input int p, input int nb, input int k);
    logic [31:0] d;
    int i;
    for (int b = 0; b < nb; b++) begin
      d = rnd();
      rxd[p*32 +: 32] <= d;
      rxl[p] <= (b == nb - 1);
      rxv[p] <= 1'h1;
      exq[k][p].push_back({b == nb - 1, d});
      for (i = 0; i < 100; i++) begin
        @(posedge clk);
        if (rxr[p]) break;
      end
      if (i == 100) to_fail();
    end
    rxv[p] <= 1'h0;
    rxd[p*32 +: 32] <= ~d;
  endtask

  task automatic hold_chk(input int p);
    repeat (8) begin
      @(posedge clk);
      chk_reg(34'(rxr[p]), 34'h0);
    end
  endtask

  task automatic take(input int k, input logic [1:0] s, input logic [32:0] g);
    if (exq[k][s].size() == 0) begin
      n_mismatch++;
      $display("wrong value at %0t: unexpected beat on output %0d", $time, k);
    end else begin
      chk_beat({1'h1, s, g}, {1'h1, s, exq[k][s].pop_front()});
    end
  endtask

  always @(posedge clk) begin
    if (!rst) begin
      if (o0v && o0r && (!rep || o1r)) take(0, o0s, {o0l, o0d});
      if (!rep && o1v && o1r) take(1, o1s, {o1l, o1d});
      if (rep && o0v) chk_beat({o1v, o1s, o1l, o1d}, {o0v, o0s, o0l, o0d});
    end
  end

  initial begin
    rst = 1'h1;
    ce = 1'h1;
    rep = 1'h0;
    rs = 32'h0000_0058;
    wstrb = 4'hf;
    {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, r} = '0;
    {rxv, rxl, rxs, rxd} = '0;
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    axr(rfw_pkg::ADDR_PORT_CTL, 32'h0000_00f0, rfw_pkg::RESP_OKAY);
    axr(rfw_pkg::ADDR_MODE_CTL, 32'h0000_0003, rfw_pkg::RESP_OKAY);
    axr(rfw_pkg::ADDR_STATUS, 32'h0000_0000, rfw_pkg::RESP_OKAY);
    axr(12'h0fc, 32'h0000_0000, rfw_pkg::RESP_SLVERR);
    axw(12'h0fc, 32'h0000_000f, rfw_pkg::RESP_SLVERR);
    axr(rfw_pkg::ADDR_PORT_CTL, 32'h0000_00f0, rfw_pkg::RESP_OKAY);
    rxv[0] <= 1'h1;
    hold_chk(0);
    rxv[0] <= 1'h0;
    repeat (3) begin
      axw(rfw_pkg::ADDR_PORT_CTL, 32'(r[3:0]) | 32'h0000_00f0, rfw_pkg::RESP_OKAY);
      r = rnd();
      axw(rfw_pkg::ADDR_PORT_CTL, 32'(r[3:0]) | 32'h0000_00f0, rfw_pkg::RESP_OKAY);
      axw(rfw_pkg::ADDR_PORT_CTL, 32'(r[3:0]), rfw_pkg::RESP_OKAY);
      axr(rfw_pkg::ADDR_PORT_CTL, 32'(r[3:0]), rfw_pkg::RESP_OKAY);
      fork
        send_pkt(0, 1 + r[5:4], r[0]);
        send_pkt(1, 1 + r[7:6], r[1]);
        send_pkt(2, 1 + r[9:8], r[2]);
        send_pkt(3, 1 + r[11:10], r[3]);
      join
    end
    for (int c = 0; c < 4; c++) begin
      axw(rfw_pkg::ADDR_MODE_CTL, 32'(c * 20), rfw_pkg::RESP_OKAY);
      axr(rfw_pkg::ADDR_MODE_CTL, 32'(c * 20), rfw_pkg::RESP_OKAY);
    end
    axw(rfw_pkg::ADDR_PORT_CTL, 32'h0000_00c0, rfw_pkg::RESP_OKAY);
    axw(rfw_pkg::ADDR_MODE_CTL, 32'h0000_0004, rfw_pkg::RESP_OKAY);
    fork
      send_pkt(0, 2, 0);
      begin
        hold_chk(0);
        send_pkt(1, 2, 0);
      end
    join
    axw(rfw_pkg::ADDR_PORT_CTL, 32'h0000_0086, rfw_pkg::RESP_OKAY);
    axw(rfw_pkg::ADDR_MODE_CTL, 32'h0000_0054, rfw_pkg::RESP_OKAY);
    send_pkt(1, 2, 1);
    send_pkt(0, 2, 0);
    send_pkt(2, 1, 1);
    // a short packet must wait for the whole round even when sending as ready
    rxs[1] <= 1'h1;
    fork
      send_pkt(1, 1, 1);
      begin
        hold_chk(1);
        send_pkt(2, 1, 1);
      end
    join
    rxs[1] <= 1'h0;
    // let output 1 drain before it starts mirroring output 0
    repeat (10) @(posedge clk);
    axw(rfw_pkg::ADDR_PORT_CTL, 32'h0000_0000, rfw_pkg::RESP_OKAY);
    axw(rfw_pkg::ADDR_MODE_CTL, 32'h0000_0081, rfw_pkg::RESP_OKAY);
    rep <= 1'h1;
    fork
      send_pkt(0, 3, 0);
      send_pkt(3, 2, 0);
    join
    repeat (20) @(posedge clk);
    rep <= 1'h0;
    for (int k = 0; k < 2; k++) begin
      for (int p = 0; p < 4; p++) begin
        chk_reg(34'(exq[k][p].size()), 34'h0);
      end
    end
    print_verdict();
  end
endmodule
